// *** hw/tap_defs.svh ***
// Overview of operation
// - Unprogrammed device keeps pad enable inactive.
// - Sample never enables pads while unprogrammed.
// - Decode EXTEST, SAMPLE/PRELOAD, BYPASS and IDCODE.
// - Five dedicated test pins form the port.
// - Sixteen-state controller in four state bits.
// - Mode select sampled on rising test clock.
// - Pin scan operations restricted until programmed.
// - Power-up lands in Test-Logic-Reset.
// - Five mode-select-high clocks force reset.
// - Test reset asynchronously forces Test-Logic-Reset.
// - Bypass, identification and boundary data registers.
// - Bypass selected when nothing else is.
// - Identification is 32 bits, four fields.
// - Three scan cells per I/O pin.
// - Cells chained from data in to out.
// - Cells tap core and buffer ports.
// - Opcodes 00 EXTEST, 01 SAMPLE, FF BYPASS.
// - Test reset initializes the test-clock scan circuitry; reset_n clears the system-side ir_out copy.
`ifndef TAP_DEFS_SVH
`define TAP_DEFS_SVH
`define IR_WIDTH       8
`define OP_EXTEST      8'h00
`define OP_SAMPLE      8'h01
`define OP_CLAMP       8'h05
`define OP_HIGHZ       8'h07
`define OP_USERCODE    8'h0e
`define OP_IDCODE      8'h0f
`define OP_BYPASS      8'hff
`define IR_CAPTURE     8'h01
`define ID_WIDTH       32
`define NUM_PINS       4
`define BSR_LEN        12
`define RESET_TMS_CNT  5
`define TCK_DIV        8
`endif

// *** hw/tap_pkg.sv ***
package tap_pkg;
   typedef enum logic [3:0] {
      TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
      SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
   } tap_state_t;
   typedef enum logic [1:0] {SEL_BYP, SEL_ID, SEL_USER, SEL_BSR} dr_sel_t;
endpackage : tap_pkg

// *** hw/jtag_if.sv ***
`timescale 1ns/1ps
interface jtag_if;
   logic tck;
   logic tms;
   logic tdi;
   logic tdo;
   logic tdo_oe;
   logic trst_n;
   modport device (input tck, input tms, input tdi, input trst_n, output tdo, output tdo_oe);
   modport tester (output tck, output tms, output tdi, output trst_n, input tdo, input tdo_oe);
endinterface : jtag_if

// *** hw/jtag_tap_device.sv ***
`timescale 1ns/1ps
`include "tap_defs.svh"
module jtag_tap_device
   import tap_pkg::*;
(
   jtag_if.device                 jt,
   input  wire logic              clk,
   input  wire logic              reset_n,
   input  wire logic              programmed,
   input  wire logic [31:0]       idcode_val,
   input  wire logic [31:0]       usercode_val,
   input  wire logic [`NUM_PINS-1:0] core_out,
   input  wire logic [`NUM_PINS-1:0] core_oe,
   input  wire logic [`NUM_PINS-1:0] pad_in,
   output logic [`NUM_PINS-1:0]   pad_out,
   output logic [`NUM_PINS-1:0]   pad_oe,
   output logic                   pad_en,
   output logic [`NUM_PINS-1:0]   core_in,
   output logic [`IR_WIDTH-1:0]   ir_out
);
   tap_state_t                 st_q;
   tap_state_t                 st_d;
   logic [`IR_WIDTH-1:0]       ir_sh_q;
   logic [`IR_WIDTH-1:0]       ir_q;
   logic                       byp_q;
   logic [`ID_WIDTH-1:0]       id_q;
   logic [`BSR_LEN-1:0]        bsr_sh_q;
   logic [`BSR_LEN-1:0]        bsr_up_q;
   logic                       prog_s1_q;
   logic                       prog_s2_q;
   logic [1:0]                 ir_s1_q;
   logic [1:0]                 ir_s2_q;
   logic [`IR_WIDTH-1:0]       ir_cap_q;
   dr_sel_t                    sel;
   logic                       ext_mode;
   logic                       tdo_d;
   logic [`BSR_LEN-1:0]        bsr_par;
   logic                       idle_q;

   // The programmed flag arrives from the configuration domain.
   always_ff @(posedge jt.tck or negedge jt.trst_n) begin
      if (!jt.trst_n) begin
         prog_s1_q <= 1'b0;
         prog_s2_q <= 1'b0;
      end else begin
         prog_s1_q <= programmed;
         prog_s2_q <= prog_s1_q;
      end
   end

   always_comb begin
      unique case (st_q)
         TLR:     st_d = jt.tms ? TLR    : RTI;
         RTI:     st_d = jt.tms ? SEL_DR : RTI;
         SEL_DR:  st_d = jt.tms ? SEL_IR : CAP_DR;
         CAP_DR:  st_d = jt.tms ? EX1_DR : SH_DR;
         SH_DR:   st_d = jt.tms ? EX1_DR : SH_DR;
         EX1_DR:  st_d = jt.tms ? UPD_DR : PA_DR;
         PA_DR:   st_d = jt.tms ? EX2_DR : PA_DR;
         EX2_DR:  st_d = jt.tms ? UPD_DR : SH_DR;
         UPD_DR:  st_d = jt.tms ? SEL_DR : RTI;
         SEL_IR:  st_d = jt.tms ? TLR    : CAP_IR;
         CAP_IR:  st_d = jt.tms ? EX1_IR : SH_IR;
         SH_IR:   st_d = jt.tms ? EX1_IR : SH_IR;
         EX1_IR:  st_d = jt.tms ? UPD_IR : PA_IR;
         PA_IR:   st_d = jt.tms ? EX2_IR : PA_IR;
         EX2_IR:  st_d = jt.tms ? UPD_IR : SH_IR;
         UPD_IR:  st_d = jt.tms ? SEL_DR : RTI;
      endcase
   end

   always_ff @(posedge jt.tck or negedge jt.trst_n) begin
      if (!jt.trst_n) st_q <= TLR;
      else st_q <= st_d;
   end

   always_ff @(posedge jt.tck or negedge jt.trst_n) begin
      if (!jt.trst_n) begin
         ir_sh_q <= `IR_CAPTURE;
         ir_q    <= `OP_IDCODE;
      end else begin
         if (st_q == TLR) ir_q <= `OP_IDCODE;
         if (st_q == CAP_IR) ir_sh_q <= `IR_CAPTURE;
         else if (st_q == SH_IR) ir_sh_q <= {jt.tdi, ir_sh_q[`IR_WIDTH-1:1]};
         if (st_q == UPD_IR) ir_q <= ir_sh_q;
      end
   end

   always_comb begin
      unique case (ir_q)
         `OP_EXTEST, `OP_SAMPLE: sel = SEL_BSR;
         `OP_IDCODE:             sel = SEL_ID;
         `OP_USERCODE:           sel = SEL_USER;
         default:                sel = SEL_BYP;
      endcase
   end

   // Pin-driving instructions take effect only once programmed.
   assign ext_mode = prog_s2_q && (ir_q == `OP_EXTEST);

   // Each pin contributes input, output and enable cells.
   for (genvar i = 0; i < `NUM_PINS; i++) begin : g_cell
      assign bsr_par[3*i]   = pad_in[i] & prog_s2_q;
      assign bsr_par[3*i+1] = core_out[i];
      assign bsr_par[3*i+2] = core_oe[i];
   end

   always_ff @(posedge jt.tck or negedge jt.trst_n) begin
      if (!jt.trst_n) begin
         byp_q    <= 1'b0;
         id_q     <= '0;
         bsr_sh_q <= '0;
         bsr_up_q <= '0;
      end else begin
         if (st_q == CAP_DR) begin
            byp_q    <= 1'b0;
            id_q     <= (sel == SEL_USER) ? usercode_val : idcode_val;
            bsr_sh_q <= bsr_par;
         end else if (st_q == SH_DR) begin
            byp_q    <= jt.tdi;
            id_q     <= {jt.tdi, id_q[`ID_WIDTH-1:1]};
            bsr_sh_q <= {jt.tdi, bsr_sh_q[`BSR_LEN-1:1]};
         end
         if (st_q == UPD_DR && sel == SEL_BSR) bsr_up_q <= bsr_sh_q;
      end
   end

   always_comb begin
      unique case (sel)
         SEL_BSR:          tdo_d = bsr_sh_q[0];
         SEL_ID, SEL_USER: tdo_d = id_q[0];
         SEL_BYP:          tdo_d = byp_q;
      endcase
      if (st_q == SH_IR) tdo_d = ir_sh_q[0];
   end

   // Output changes on the falling edge so the tester samples a stable bit.
   always_ff @(negedge jt.tck or negedge jt.trst_n) begin
      if (!jt.trst_n) begin
         jt.tdo    <= 1'b0;
         jt.tdo_oe <= 1'b0;
      end else begin
         jt.tdo    <= tdo_d;
         jt.tdo_oe <= (st_q == SH_DR) || (st_q == SH_IR);
      end
   end

   always_comb begin
      pad_en  = prog_s2_q;
      core_in = pad_in & {`NUM_PINS{prog_s2_q}};
      for (int i = 0; i < `NUM_PINS; i++) begin
         pad_out[i] = ext_mode ? bsr_up_q[3*i+1] : core_out[i];
         pad_oe[i]  = prog_s2_q & (ext_mode ? bsr_up_q[3*i+2] : core_oe[i]);
      end
   end

   // A registered idle flag crosses, so no decoder glitch reaches the other clock.
   always_ff @(posedge jt.tck or negedge jt.trst_n) begin
      if (!jt.trst_n) idle_q <= 1'b0;
      else idle_q <= (st_d == RTI);
   end

   // The instruction is stable while idle, so it is taken after the flag is synced.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ir_s1_q  <= '0;
         ir_s2_q  <= '0;
         ir_cap_q <= '0;
      end else begin
         ir_s1_q  <= {ir_s1_q[0], idle_q};
         ir_s2_q  <= {ir_s2_q[0], ir_s1_q[1]};
         if (ir_s2_q == 2'b01) ir_cap_q <= ir_q;
      end
   end
   assign ir_out = ir_cap_q;
endmodule : jtag_tap_device

// *** hw/jtag_tester.sv ***
`timescale 1ns/1ps
`include "tap_defs.svh"
module jtag_tester
   import tap_pkg::*;
(
   jtag_if.tester                jt,
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic             start,
   input  wire logic             is_ir,
   input  wire logic             force_reset,
   input  wire logic [5:0]       len,
   input  wire logic [31:0]      data_in,
   output logic                  busy,
   output logic                  done,
   output logic [31:0]           data_out
);
   typedef enum logic [2:0] {T_IDLE, T_RST, T_HEAD, T_SHIFT, T_TAIL} tst_t;
   tst_t             st_q;
   logic [3:0]       div_q;
   logic [5:0]       cnt_q;
   logic [31:0]      sh_q;
   logic [1:0]       tdo_s_q;
   logic             tck_q;
   logic             fall;
   logic             rise;

   // The tester makes the test clock by dividing its own clock.
   assign fall = (div_q == 4'(`TCK_DIV/2 - 1)) && tck_q;
   assign rise = (div_q == 4'(`TCK_DIV/2 - 1)) && !tck_q;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         div_q <= '0;
         tck_q <= 1'b0;
      end else if (st_q == T_IDLE && !tck_q) begin
         div_q <= '0;
      end else if (div_q == 4'(`TCK_DIV/2 - 1)) begin
         div_q <= '0;
         tck_q <= ~tck_q;
      end else begin
         div_q <= div_q + 4'h1;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) tdo_s_q <= '0;
      else tdo_s_q <= {tdo_s_q[0], jt.tdo};
   end

   // TMS and TDI change on the falling edge, ahead of the rising sample.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_q     <= T_IDLE;
         cnt_q    <= '0;
         sh_q     <= '0;
         jt.tms   <= 1'b1;
         jt.tdi   <= 1'b1;
         done     <= 1'b0;
         data_out <= '0;
      end else begin
         done <= 1'b0;
         unique case (st_q)
            T_IDLE: if (start) begin
               sh_q  <= data_in;
               cnt_q <= '0;
               st_q  <= force_reset ? T_RST : T_HEAD;
            end
            T_RST: if (fall) begin
               jt.tms <= 1'b1;
               cnt_q  <= cnt_q + 6'h1;
               if (cnt_q == 6'(`RESET_TMS_CNT)) begin
                  jt.tms <= 1'b0;
                  st_q   <= T_IDLE;
                  done   <= 1'b1;
               end
            end
            T_HEAD: if (fall) begin
               // A leading 0 also leaves Test-Logic-Reset, so either it or Run-Test/Idle may be the start state.
               cnt_q <= cnt_q + 6'h1;
               unique case (cnt_q)
                  6'h0: jt.tms <= 1'b0;
                  6'h1: jt.tms <= 1'b1;
                  6'h2: jt.tms <= is_ir;
                  default: jt.tms <= 1'b0;
               endcase
               if (cnt_q == (is_ir ? 6'h5 : 6'h4)) begin
                  cnt_q  <= '0;
                  jt.tdi <= sh_q[0];
                  jt.tms <= (len == 6'h1);
                  st_q   <= T_SHIFT;
               end
            end
            T_SHIFT: begin
               if (rise) sh_q <= {tdo_s_q[1], sh_q[31:1]};
               if (fall) begin
                  cnt_q  <= cnt_q + 6'h1;
                  jt.tdi <= sh_q[0];
                  jt.tms <= (cnt_q == len - 6'h2);
                  if (cnt_q == len - 6'h1) begin
                     cnt_q  <= '0;
                     jt.tms <= 1'b1;
                     st_q   <= T_TAIL;
                  end
               end
            end
            T_TAIL: if (fall) begin
               cnt_q  <= cnt_q + 6'h1;
               jt.tms <= 1'b0;
               if (cnt_q == 6'h1) begin
                  st_q     <= T_IDLE;
                  done     <= 1'b1;
                  data_out <= sh_q >> (6'd32 - len);
               end
            end
         endcase
      end
   end

   assign jt.tck    = tck_q;
   assign jt.trst_n = reset_n;
   assign busy      = (st_q != T_IDLE);
endmodule : jtag_tester

// *** sim/jtag_tap_sva.sv ***
`timescale 1ns/1ps
module jtag_tap_sva
   import tap_pkg::*;
(
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic tdo,
   input wire logic tdo_oe,
   input wire logic trst_n
);
   tap_state_t st_q;
   logic       first_q;
   function automatic tap_state_t nxt(input tap_state_t s, input logic m);
      case (s)
         TLR:     return m ? TLR : RTI;
         RTI:     return m ? SEL_DR : RTI;
         SEL_DR:  return m ? SEL_IR : CAP_DR;
         CAP_DR:  return m ? EX1_DR : SH_DR;
         SH_DR:   return m ? EX1_DR : SH_DR;
         EX1_DR:  return m ? UPD_DR : PA_DR;
         PA_DR:   return m ? EX2_DR : PA_DR;
         EX2_DR:  return m ? UPD_DR : SH_DR;
         SEL_IR:  return m ? TLR : CAP_IR;
         CAP_IR:  return m ? EX1_IR : SH_IR;
         SH_IR:   return m ? EX1_IR : SH_IR;
         EX1_IR:  return m ? UPD_IR : PA_IR;
         PA_IR:   return m ? EX2_IR : PA_IR;
         EX2_IR:  return m ? UPD_IR : SH_IR;
         default: return m ? SEL_DR : RTI;
      endcase
   endfunction : nxt
   // A mirror of the controller lets the wire be judged state by state.
   always_ff @(posedge tck or negedge trst_n) begin
      if (!trst_n) begin
         st_q    <= TLR;
         first_q <= 1'b1;
      end else begin
         st_q    <= nxt(st_q, tms);
         first_q <= 1'b0;
      end
   end
   default clocking cb @(posedge tck); endclocking
   default disable iff (!trst_n);
   sequence s_dr_entry;
      st_q == RTI && tms ##1 !tms ##1 !tms;
   endsequence
   sequence s_ir_entry;
      st_q == RTI && tms ##1 tms ##1 !tms ##1 !tms;
   endsequence
   a_dr_shift_oe: assert property (s_dr_entry |=> tdo_oe) else $error("dr shift oe");
   a_ir_shift_oe: assert property (s_ir_entry |=> tdo_oe) else $error("ir shift oe");
   a_oe_in_shift: assert property (st_q inside {SH_DR, SH_IR} |-> tdo_oe)
      else $error("oe low in shift");
   a_oe_off_shift: assert property (!(st_q inside {SH_DR, SH_IR}) |-> !tdo_oe)
      else $error("oe high outside shift");
   a_five_high_reset: assert property (tms [*5] |=> !tdo_oe) else $error("tms reset");
   a_exit_to_update: assert property (st_q inside {EX1_DR, EX1_IR} |-> tms)
      else $error("pause taken");
   a_update_to_idle: assert property (st_q inside {UPD_DR, UPD_IR} |-> !tms)
      else $error("no idle");
   a_release_quiet: assert property (first_q |-> !tdo_oe && !tdo)
      else $error("output not cleared by reset");
endmodule : jtag_tap_sva

// *** sim/jtag_boundary_scan_tap_tb.sv ***
`timescale 1ns/1ps
`include "tap_defs.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; $display("wrong value at %0t: mismatch", $time); end end
module jtag_boundary_scan_tap_tb
   import tap_pkg::*;
   ;
   logic        clk, reset_n, programmed, start, is_ir, force_reset, busy, done, pad_en;
   logic [31:0] idcode_val, usercode_val, data_in, data_out, din;
   logic [3:0]  core_out, core_oe, pad_in, pad_out, pad_oe, core_in;
   logic [5:0]  len;
   logic [7:0]  ir_out;
   logic [7:0]  ops [8];
   int          num_errors, compares, j, k;
   jtag_if jt_if ();
   jtag_tester jtag_tester_inst (.jt(jt_if), .clk, .reset_n, .start, .is_ir, .force_reset,
      .len, .data_in, .busy, .done, .data_out);
   jtag_tap_device jtag_tap_device_inst (.jt(jt_if), .clk, .reset_n, .programmed, .idcode_val,
      .usercode_val, .core_out, .core_oe, .pad_in, .pad_out, .pad_oe, .pad_en, .core_in, .ir_out);
   jtag_tap_sva jtag_tap_sva_inst (.tck(jt_if.tck), .tms(jt_if.tms), .tdi(jt_if.tdi),
      .tdo(jt_if.tdo), .tdo_oe(jt_if.tdo_oe), .trst_n(jt_if.trst_n));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task end_sim;
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : end_sim
   task scan(input logic ir, input logic [5:0] n, input logic [31:0] d, input logic fr);
      int i;
      @(posedge clk);
      {start, is_ir, len, data_in, force_reset} <= {1'b1, ir, n, d, fr};
      @(posedge clk);
      start <= 1'b0;
      for (i = 0; i < 1000; i++) begin
         @(posedge clk);
         #1;
         if (done === 1'b1) break;
      end
      if (i == 1000) begin
         num_errors++;
         end_sim();
      end
   endtask : scan
   // The opcode lands on the system side only after the controller reaches idle.
   task wait_ir(input logic [7:0] op);
      for (int i = 0; i < 64 && ir_out !== op; i++) begin
         @(posedge clk);
         #1;
      end
      `CHK(ir_out, op)
   endtask : wait_ir
   function automatic logic [31:0] exp_dr(input logic [7:0] op, input logic [31:0] d);
      case (op)
         `OP_IDCODE:   return idcode_val;
         `OP_USERCODE: return usercode_val;
         default:      return {d[30:0], 1'b0};
      endcase
   endfunction : exp_dr
   initial begin
      {reset_n, programmed, start, is_ir, force_reset} = 5'h00;
      {len, data_in, core_oe} = 42'h0;
      idcode_val = $urandom(32'hdf131f01);
      usercode_val = $urandom();
      core_out = 4'($urandom());
      pad_in = 4'($urandom());
      ops = '{`OP_EXTEST, `OP_SAMPLE, `OP_CLAMP, `OP_HIGHZ, `OP_USERCODE, `OP_IDCODE,
              `OP_BYPASS, 8'h10 + 8'($urandom_range(0, 223))};
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      scan(1'b0, 6'd32, 32'h0, 1'b0);
      `CHK(data_out, idcode_val)
      for (k = 0; k < 2; k++) begin
         programmed <= k[0];
         for (j = 0; j < 8; j++) begin
            {core_out, core_oe, pad_in} <= 12'($urandom());
            scan(1'b1, 6'd8, {24'h0, ops[j]}, 1'b0);
            `CHK(data_out[7:0], `IR_CAPTURE)
            wait_ir(ops[j]);
            din = $urandom();
            scan(1'b0, 6'd32, din, 1'b0);
            // Only the bits past the twelve captured cells are fixed by the chain length.
            if (ops[j] inside {`OP_EXTEST, `OP_SAMPLE}) `CHK(data_out[31:12], din[19:0])
            else `CHK(data_out, exp_dr(ops[j], din))
            `CHK(pad_en, programmed)
            if (!programmed) `CHK(pad_oe, 4'h0)
            if (ops[j] == `OP_EXTEST && programmed) begin
               `CHK(pad_out, {din[30], din[27], din[24], din[21]})
               `CHK(pad_oe, {din[31], din[28], din[25], din[22]})
            end
            if (ops[j] == `OP_SAMPLE && programmed)
               `CHK({pad_out, pad_oe, core_in}, {core_out, core_oe, pad_in})
         end
      end
      scan(1'b0, 6'd1, 32'h1, 1'b0);
      `CHK(data_out[0], 1'b0)
      scan(1'b0, 6'd1, 32'h0, 1'b1);
      scan(1'b0, 6'd32, 32'h0, 1'b0);
      `CHK(data_out, idcode_val)
      wait_ir(`OP_IDCODE);
      scan(1'b1, 6'd8, 32'hff, 1'b0);
      @(posedge clk);
      {start, is_ir, len} <= {1'b1, 1'b0, 6'd32};
      @(posedge clk);
      start <= 1'b0;
      repeat (100) @(posedge clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      #1;
      `CHK(jt_if.tdo_oe, 1'b0)
      scan(1'b0, 6'd32, 32'h0, 1'b0);
      `CHK(data_out, idcode_val)
      end_sim();
   end
endmodule : jtag_boundary_scan_tap_tb
